// ==== rtl/phy_codec_pkg.sv ====
package phy_codec_pkg;

    // Clock
    localparam int CLK_MHZ = 25;
    localparam int CLK_NS  = 40;

    // 100BASE-X code-groups
    localparam logic [4:0] CG_I = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] DATA_CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
                                              5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
                                              5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_BAD_SSD  = 4'hE;
    localparam logic [2:0] GRP_LAST     = 3'h4;

    // Descrambler
    localparam logic [4:0] LOCK_RUN     = 5'h1D;
    localparam logic [3:0] IDLE_BITS    = 4'hA;
    localparam int         IDLE_WIN_US  = 40;
    localparam int         IDLE_WIN_CYC = IDLE_WIN_US * CLK_MHZ;
    localparam logic [9:0] IDLE_WIN_LAST = 10'(IDLE_WIN_CYC - 1);

    // 10M timing: 20 MHz half-bit enable made from 25 MHz by a 4/5 accumulator
    localparam logic [3:0] MAN_STEP      = 4'h4;
    localparam logic [3:0] MAN_MOD       = 4'h5;
    localparam int         NLP_PERIOD_MS = 16;
    localparam int         NLP_PERIOD_CYC = NLP_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int         NLP_WIDTH_NS  = 100;
    localparam logic [1:0] NLP_WIDTH_CYC = 2'((NLP_WIDTH_NS + CLK_NS - 1) / CLK_NS);
    localparam int         NLP_MAX_NS    = 300;
    localparam logic [3:0] NLP_MAX_CYC   = 4'(NLP_MAX_NS / CLK_NS);
    localparam int         JABBER_MS     = 45;
    localparam int         JABBER_CYC    = JABBER_MS * 1000 * CLK_MHZ;
    localparam int         LINK_LOSS_MS  = 100;
    localparam int         LINK_LOSS_CYC = LINK_LOSS_MS * 1000 * CLK_MHZ;
    localparam logic [2:0] MID_MIN       = 3'h2;
    localparam int         CNT_W         = 22;

    typedef enum logic [1:0] {HUNT, SSD_K, FRAME, ESD_R} rx100_state_t;

endpackage

// ==== rtl/code_group_decoder.sv ====
`timescale 1ns/1ps
module code_group_decoder (
    input  wire logic [4:0] grp,
    output logic      [3:0] nib,
    output logic            is_data
);
    import phy_codec_pkg::*;

    logic [15:0] hit;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_cmp
            assign hit[i] = (grp == DATA_CODE[i]); // R22
        end
    endgenerate

    always_comb begin
        nib = 4'h0;
        for (int k = 0; k < 16; k++) begin
            if (hit[k]) begin
                nib = 4'(k);
            end
        end
    end

    assign is_data = |hit;

endmodule // code_group_decoder

// ==== rtl/manchester_tx_jabber.sv ====
`timescale 1ns/1ps
module manchester_tx_jabber (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           enable,
    input  wire logic                           txen,
    input  wire logic [3:0]                     txd,
    input  wire logic [phy_codec_pkg::CNT_W-1:0] nlp_period,
    input  wire logic [phy_codec_pkg::CNT_W-1:0] jabber_limit,
    output logic                                nib_stb,
    output logic                                line,
    output logic                                drive,
    output logic                                jabber
);
    import phy_codec_pkg::*;

    logic [3:0]       acc_r, acc_nxt, sum;
    logic [2:0]       half_r, half_nxt;
    logic [3:0]       sh_r, sh_nxt;
    logic             busy_r, busy_nxt;
    logic             line_r, line_nxt;
    logic [1:0]       pw_r, pw_nxt;
    logic [CNT_W-1:0] nlp_r, nlp_nxt;
    logic [CNT_W-1:0] jcnt_r, jcnt_nxt;
    logic             jab_r, jab_nxt;
    logic             en, bitv;

    always_comb begin
        sum      = acc_r + MAN_STEP;
        en       = (sum >= MAN_MOD); // R12
        acc_nxt  = en ? sum - MAN_MOD : sum;
        half_nxt = half_r;
        sh_nxt   = sh_r;
        busy_nxt = busy_r;
        line_nxt = line_r;
        pw_nxt   = pw_r;
        nlp_nxt  = nlp_r;
        jcnt_nxt = jcnt_r;
        jab_nxt  = jab_r;
        nib_stb  = en && (half_r == 3'h0) && txen && !jab_r && enable; // R11
        bitv     = 1'b0;
        if (!txen) begin
            jcnt_nxt = '0;
            jab_nxt  = 1'b0; // R18
        end else if (jcnt_r == jabber_limit - 1'b1) begin
            jab_nxt = 1'b1; // R17
        end else begin
            jcnt_nxt = jcnt_r + 1'b1;
        end
        if (en) begin
            if (half_r == 3'h0) begin
                busy_nxt = nib_stb;
                if (nib_stb) begin
                    sh_nxt = txd; // R11
                end
            end
            if (busy_nxt) begin
                bitv     = sh_nxt[half_r[2:1]];
                line_nxt = half_r[0] ? bitv : !bitv; // R12
                half_nxt = half_r + 3'h1;
            end else begin
                half_nxt = 3'h0;
            end
        end
        if (jab_nxt) begin
            busy_nxt = 1'b0; // R17
            half_nxt = 3'h0;
        end
        if (busy_nxt || txen || !enable) begin
            nlp_nxt = '0;
            pw_nxt  = 2'h0;
        end else begin
            if (pw_r != 2'h0) begin
                pw_nxt = pw_r - 2'h1;
            end
            if (nlp_r == nlp_period - 1'b1) begin
                nlp_nxt = '0;
                pw_nxt  = NLP_WIDTH_CYC; // R13
            end else begin
                nlp_nxt = nlp_r + 1'b1;
            end
        end
        if (!busy_nxt) begin
            line_nxt = (pw_nxt != 2'h0);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_r  <= 4'h0;
            half_r <= 3'h0;
            sh_r   <= 4'h0;
            busy_r <= 1'b0;
            line_r <= 1'b0;
            pw_r   <= 2'h0;
            nlp_r  <= '0;
            jcnt_r <= '0;
            jab_r  <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            half_r <= half_nxt;
            sh_r   <= sh_nxt;
            busy_r <= busy_nxt;
            line_r <= line_nxt;
            pw_r   <= pw_nxt;
            nlp_r  <= nlp_nxt;
            jcnt_r <= jcnt_nxt;
            jab_r  <= jab_nxt;
        end
    end

    assign line   = line_r;
    assign drive  = busy_r || (pw_r != 2'h0);
    assign jabber = jab_r;

endmodule // manchester_tx_jabber

// ==== rtl/ethernet_phy_line_codec.sv ====
`timescale 1ns/1ps
// Summary of operation
// R1: MLT-3 levels converted to NRZI first
// R2: Descrambler learns key on idle, then locks
// R3: No idle within 40us aborts, resynchronises
// R4: J/K pair sets group alignment per frame
// R5: Valid code-groups decoded to RXD nibbles
// R6: J/K delivered as two 0101 nibbles
// R7: J/K raises RXDV; later groups become data
// R8: T/R or two idles end frame silently
// R9: Unexpected group in frame asserts RXER
// R10: Bad start delimiter: RXER, RXD 1110, no RXDV
// R11: MAC nibbles at 2.5MHz serialised to 10Mbps
// R12: Manchester encoding on derived 20MHz rate
// R13: Link pulses sent while TXEN low
// R14: Reversed receive pair detected, corrected, flagged
// R15: 10M receive decodes Manchester into nibbles
// R16: Received link pulses keep 10M link up
// R17: Jabber stops line drive within 45ms
// R18: Jabber state clears when TXEN drops
// R19: J 11000 after idle, K 10001 after J
// R20: T 01101 then R 00111 ends carrier
// R21: Invalid code-groups raise RXER during RXDV
// R22: Standard 4B/5B data code assignment
// R23: Nibble handoff paced per MII speed
module ethernet_phy_line_codec #(
    parameter int unsigned NLP_PERIOD   = phy_codec_pkg::NLP_PERIOD_CYC,
    parameter int unsigned JABBER_LIMIT = phy_codec_pkg::JABBER_CYC,
    parameter int unsigned LINK_LOSS    = phy_codec_pkg::LINK_LOSS_CYC
) (
    input  wire logic       MCLK,
    input  wire logic       NRST,
    input  wire logic       SPEED100,
    input  wire logic [1:0] MLT3_LEVEL,
    input  wire logic       MLT3_VALID,
    input  wire logic       RX10_LINE,
    input  wire logic       RX10_SQ,
    input  wire logic       TXEN,
    input  wire logic [3:0] TXD,
    output logic      [3:0] RXD,
    output logic            RXDV,
    output logic            RXER,
    output logic            CRS,
    output logic            RX_NIB_STB,
    output logic            DESCR_LOCKED,
    output logic            POLARITY_REVERSED_FLAG,
    output logic            LINK10_UP,
    output logic            TX_NIB_STB,
    output logic            TX10_LINE,
    output logic            TX10_DRIVE,
    output logic            JABBER
);
    import phy_codec_pkg::*;

    localparam logic [CNT_W-1:0] LINK_LAST = CNT_W'(LINK_LOSS - 1);

    // 100M front end: NRZI and descrambler
    logic [1:0]       lvl_prev_r, lvl_prev_nxt;
    logic             nrzi_r, nrzi_nxt;
    logic [10:0]      key_r, key_nxt;
    logic             lock_r, lock_nxt;
    logic [4:0]       match_r, match_nxt;
    logic [3:0]       idle_run_r, idle_run_nxt;
    logic [9:0]       win_r, win_nxt;
    logic             bit_v_r, bit_v_nxt;
    logic             bit_r, bit_nxt;
    logic             abort_r, abort_nxt;
    logic             s_bit, pred, d_bit;

    always_comb begin
        lvl_prev_nxt = lvl_prev_r;
        nrzi_nxt     = nrzi_r;
        key_nxt      = key_r;
        lock_nxt     = lock_r;
        match_nxt    = match_r;
        idle_run_nxt = idle_run_r;
        bit_v_nxt    = 1'b0;
        bit_nxt      = bit_r;
        abort_nxt    = 1'b0;
        win_nxt      = win_r + 10'h001;
        pred         = key_r[10] ^ key_r[8];
        s_bit        = 1'b0;
        d_bit        = 1'b0;
        if (MLT3_VALID) begin
            lvl_prev_nxt = MLT3_LEVEL;
            nrzi_nxt     = nrzi_r ^ (MLT3_LEVEL != lvl_prev_r); // R1
            s_bit        = nrzi_nxt ^ nrzi_r;
            if (!lock_r) begin
                key_nxt = {key_r[9:0], !s_bit}; // R2
                if (!s_bit == pred) begin
                    match_nxt = match_r + 5'h01;
                    if (match_r == LOCK_RUN) begin
                        lock_nxt = 1'b1; // R2
                    end
                end else begin
                    match_nxt = 5'h00;
                end
            end else begin
                key_nxt   = {key_r[9:0], pred};
                d_bit     = s_bit ^ pred;
                bit_v_nxt = 1'b1;
                bit_nxt   = d_bit;
                if (!d_bit) begin
                    idle_run_nxt = 4'h0;
                end else if (idle_run_r != IDLE_BITS) begin
                    idle_run_nxt = idle_run_r + 4'h1;
                end
            end
        end
        if (!lock_r || idle_run_r == IDLE_BITS) begin
            win_nxt = 10'h000;
        end else if (win_r == IDLE_WIN_LAST) begin
            lock_nxt     = 1'b0; // R3
            match_nxt    = 5'h00;
            idle_run_nxt = 4'h0;
            abort_nxt    = 1'b1;
            bit_v_nxt    = 1'b0;
            win_nxt      = 10'h000;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            lvl_prev_r <= 2'h0;
            nrzi_r     <= 1'b0;
            key_r      <= 11'h000;
            lock_r     <= 1'b0;
            match_r    <= 5'h00;
            idle_run_r <= 4'h0;
            win_r      <= 10'h000;
            bit_v_r    <= 1'b0;
            bit_r      <= 1'b0;
            abort_r    <= 1'b0;
        end else begin
            lvl_prev_r <= lvl_prev_nxt;
            nrzi_r     <= nrzi_nxt;
            key_r      <= key_nxt;
            lock_r     <= lock_nxt;
            match_r    <= match_nxt;
            idle_run_r <= idle_run_nxt;
            win_r      <= win_nxt;
            bit_v_r    <= bit_v_nxt;
            bit_r      <= bit_nxt;
            abort_r    <= abort_nxt;
        end
    end

    // 100M alignment and 5B/4B decode
    rx100_state_t st_r, st_nxt;
    logic [9:0]   sh_r, sh_nxt;
    logic [2:0]   cnt_r, cnt_nxt;
    logic         idle_seen_r, idle_seen_nxt;
    logic         pend_r, pend_nxt;
    logic [3:0]   rxd100_r, rxd100_nxt;
    logic         rxdv100_r, rxdv100_nxt;
    logic         rxer100_r, rxer100_nxt;
    logic         crs100_r, crs100_nxt;
    logic         stb100_r, stb100_nxt;
    logic [4:0]   grp;
    logic [3:0]   dec_nib;
    logic         dec_data;
    logic         grp_end;

    assign grp     = {sh_r[3:0], bit_r};
    assign grp_end = bit_v_r && (cnt_r == GRP_LAST);

    code_group_decoder u_dec (
        .grp     (grp),
        .nib     (dec_nib),
        .is_data (dec_data)
    );

    always_comb begin
        st_nxt        = st_r;
        sh_nxt        = sh_r;
        cnt_nxt       = cnt_r;
        idle_seen_nxt = idle_seen_r;
        pend_nxt      = 1'b0;
        rxd100_nxt    = rxd100_r;
        rxdv100_nxt   = rxdv100_r;
        rxer100_nxt   = 1'b0;
        crs100_nxt    = crs100_r;
        stb100_nxt    = 1'b0;
        if (pend_r) begin
            rxd100_nxt = NIB_PREAMBLE; // R6
            stb100_nxt = 1'b1;
        end
        if (bit_v_r) begin
            sh_nxt  = {sh_r[8:0], bit_r};
            cnt_nxt = (cnt_r == GRP_LAST) ? 3'h0 : cnt_r + 3'h1;
        end
        unique case (st_r)
            HUNT: begin
                if (bit_v_r && {sh_r[8:0], bit_r} == {CG_I, CG_J}) begin
                    st_nxt     = SSD_K; // R4 R19
                    cnt_nxt    = 3'h0;
                    crs100_nxt = 1'b1;
                end
            end
            SSD_K: begin
                if (grp_end) begin
                    if (grp == CG_K) begin
                        rxd100_nxt    = NIB_PREAMBLE; // R6 R19
                        stb100_nxt    = 1'b1;
                        rxdv100_nxt   = 1'b1; // R7
                        pend_nxt      = 1'b1;
                        idle_seen_nxt = 1'b0;
                        st_nxt        = FRAME;
                    end else begin
                        rxd100_nxt  = NIB_BAD_SSD; // R10
                        rxer100_nxt = 1'b1;
                        stb100_nxt  = 1'b1;
                        crs100_nxt  = 1'b0;
                        st_nxt      = HUNT;
                    end
                end
            end
            FRAME: begin
                if (grp_end) begin
                    if (dec_data) begin
                        rxd100_nxt    = dec_nib; // R5 R7
                        stb100_nxt    = 1'b1;
                        idle_seen_nxt = 1'b0;
                    end else if (grp == CG_T) begin
                        st_nxt        = ESD_R; // R20
                        idle_seen_nxt = 1'b0;
                    end else if (grp == CG_I) begin
                        if (idle_seen_r) begin
                            rxdv100_nxt = 1'b0; // R8
                            crs100_nxt  = 1'b0;
                            st_nxt      = HUNT;
                        end
                        idle_seen_nxt = 1'b1;
                    end else begin
                        rxd100_nxt    = dec_nib; // R9 R21
                        rxer100_nxt   = 1'b1;
                        stb100_nxt    = 1'b1;
                        idle_seen_nxt = 1'b0;
                    end
                end
            end
            ESD_R: begin
                if (grp_end) begin
                    if (grp == CG_R) begin
                        rxdv100_nxt = 1'b0; // R8 R20
                        crs100_nxt  = 1'b0;
                        st_nxt      = HUNT;
                    end else begin
                        rxer100_nxt = 1'b1; // R20
                        stb100_nxt  = 1'b1;
                        st_nxt      = FRAME;
                    end
                end
            end
        endcase
        if (abort_r) begin
            st_nxt      = HUNT; // R3
            rxdv100_nxt = 1'b0;
            crs100_nxt  = 1'b0;
            pend_nxt    = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            st_r        <= HUNT;
            sh_r        <= 10'h000;
            cnt_r       <= 3'h0;
            idle_seen_r <= 1'b0;
            pend_r      <= 1'b0;
            rxd100_r    <= 4'h0;
            rxdv100_r   <= 1'b0;
            rxer100_r   <= 1'b0;
            crs100_r    <= 1'b0;
            stb100_r    <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            sh_r        <= sh_nxt;
            cnt_r       <= cnt_nxt;
            idle_seen_r <= idle_seen_nxt;
            pend_r      <= pend_nxt;
            rxd100_r    <= rxd100_nxt;
            rxdv100_r   <= rxdv100_nxt;
            rxer100_r   <= rxer100_nxt;
            crs100_r    <= crs100_nxt;
            stb100_r    <= stb100_nxt;
        end
    end

    // 10M receive: pin synchronisers
    logic line_s1_r, line_s2_r, sq_s1_r, sq_s2_r;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            line_s1_r <= 1'b0;
            line_s2_r <= 1'b0;
            sq_s1_r   <= 1'b0;
            sq_s2_r   <= 1'b0;
        end else begin
            line_s1_r <= RX10_LINE;
            line_s2_r <= line_s1_r;
            sq_s1_r   <= RX10_SQ;
            sq_s2_r   <= sq_s1_r;
        end
    end

    // 10M receive: Manchester decode, polarity, link pulses
    logic             lvl_d_r, sq_d_r, in10_r, in10_nxt;
    logic [2:0]       since_r, since_nxt;
    logic             pol_r, pol_nxt, pol_done_r, pol_done_nxt;
    logic             raw_prev_r, raw_prev_nxt, first_r, first_nxt;
    logic [3:0]       nsh_r, nsh_nxt, rxd10_r, rxd10_nxt, hi_r, hi_nxt;
    logic [1:0]       bcnt_r, bcnt_nxt;
    logic             stb10_r, stb10_nxt, link_r, link_nxt;
    logic [CNT_W-1:0] lcnt_r, lcnt_nxt;
    logic             raw, rbit;

    always_comb begin
        in10_nxt     = in10_r;
        since_nxt    = (since_r == 3'h7) ? since_r : since_r + 3'h1;
        pol_nxt      = pol_r;
        pol_done_nxt = pol_done_r;
        raw_prev_nxt = raw_prev_r;
        first_nxt    = first_r;
        nsh_nxt      = nsh_r;
        rxd10_nxt    = rxd10_r;
        bcnt_nxt     = bcnt_r;
        stb10_nxt    = 1'b0;
        hi_nxt       = sq_s2_r ? ((hi_r == 4'hF) ? hi_r : hi_r + 4'h1) : 4'h0;
        link_nxt     = link_r;
        lcnt_nxt     = lcnt_r + 1'b1;
        raw          = line_s2_r;
        rbit         = line_s2_r ^ pol_r; // R14
        if (lcnt_r == LINK_LAST) begin
            lcnt_nxt = lcnt_r;
            link_nxt = 1'b0;
        end
        if (sq_s2_r && !in10_r && hi_r == NLP_MAX_CYC) begin
            in10_nxt     = 1'b1;
            first_nxt    = 1'b1;
            pol_done_nxt = 1'b0;
            bcnt_nxt     = 2'h0;
            since_nxt    = MID_MIN;
        end
        if (!sq_s2_r && sq_d_r) begin
            in10_nxt = 1'b0;
            lcnt_nxt = '0; // R16
            link_nxt = 1'b1;
        end
        if (in10_r && sq_s2_r && line_s2_r != lvl_d_r && since_r >= MID_MIN) begin
            since_nxt = 3'h0; // R15
            if (!first_r && !pol_done_r && raw == raw_prev_r) begin
                pol_nxt      = !raw; // R14
                pol_done_nxt = 1'b1;
                rbit         = !raw ^ raw;
            end
            raw_prev_nxt = raw;
            first_nxt    = 1'b0;
            nsh_nxt      = {rbit, nsh_r[3:1]};
            bcnt_nxt     = bcnt_r + 2'h1;
            if (bcnt_r == 2'h3) begin
                rxd10_nxt = {rbit, nsh_r[3:1]}; // R15 R23
                stb10_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            lvl_d_r    <= 1'b0;
            sq_d_r     <= 1'b0;
            in10_r     <= 1'b0;
            since_r    <= 3'h0;
            pol_r      <= 1'b0;
            pol_done_r <= 1'b0;
            raw_prev_r <= 1'b0;
            first_r    <= 1'b0;
            nsh_r      <= 4'h0;
            rxd10_r    <= 4'h0;
            hi_r       <= 4'h0;
            bcnt_r     <= 2'h0;
            stb10_r    <= 1'b0;
            link_r     <= 1'b0;
            lcnt_r     <= '0;
        end else begin
            lvl_d_r    <= line_s2_r;
            sq_d_r     <= sq_s2_r;
            in10_r     <= in10_nxt;
            since_r    <= since_nxt;
            pol_r      <= pol_nxt;
            pol_done_r <= pol_done_nxt;
            raw_prev_r <= raw_prev_nxt;
            first_r    <= first_nxt;
            nsh_r      <= nsh_nxt;
            rxd10_r    <= rxd10_nxt;
            hi_r       <= hi_nxt;
            bcnt_r     <= bcnt_nxt;
            stb10_r    <= stb10_nxt;
            link_r     <= link_nxt;
            lcnt_r     <= lcnt_nxt;
        end
    end

    // 10M transmit
    manchester_tx_jabber u_tx (
        .clk          (MCLK),
        .rst_n        (NRST),
        .enable       (!SPEED100),
        .txen         (TXEN),
        .txd          (TXD),
        .nlp_period   (CNT_W'(NLP_PERIOD)),
        .jabber_limit (CNT_W'(JABBER_LIMIT)),
        .nib_stb      (TX_NIB_STB),
        .line         (TX10_LINE),
        .drive        (TX10_DRIVE),
        .jabber       (JABBER)
    );

    // MII receive mux by speed
    assign RXD                    = SPEED100 ? rxd100_r : rxd10_r; // R23
    assign RXDV                   = SPEED100 ? rxdv100_r : in10_r;
    assign RXER                   = SPEED100 && rxer100_r;
    assign CRS                    = SPEED100 ? crs100_r : in10_r;
    assign RX_NIB_STB             = SPEED100 ? stb100_r : stb10_r;
    assign DESCR_LOCKED           = lock_r;
    assign POLARITY_REVERSED_FLAG = pol_r;
    assign LINK10_UP              = link_r;

endmodule // ethernet_phy_line_codec

// ==== verification/phy_codec_sva.sv ====
`timescale 1ns/1ps
module phy_codec_chk #(
    parameter int unsigned JABBER_LIMIT = 200
) (
    input wire logic       MCLK,
    input wire logic       NRST,
    input wire logic       SPEED100,
    input wire logic       TXEN,
    input wire logic [3:0] TXD,
    input wire logic [3:0] RXD,
    input wire logic       RXDV,
    input wire logic       RXER,
    input wire logic       CRS,
    input wire logic       RX_NIB_STB,
    input wire logic       TX_NIB_STB,
    input wire logic       TX10_LINE,
    input wire logic       TX10_DRIVE,
    input wire logic       JABBER
);
    logic        txd0_r;
    logic [21:0] on_r;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    always_ff @(posedge MCLK) begin
        txd0_r <= TXD[0];
        on_r   <= (TXEN && NRST) ? on_r + 22'h1 : 22'h0;
    end
    sequence nib_taken;
        TX_NIB_STB;
    endsequence
    sequence preamble;
        RX_NIB_STB && RXD == 4'h5 ##1 RX_NIB_STB && RXD == 4'h5;
    endsequence
    a_rxer_pulse: assert property (RXER |-> RX_NIB_STB)
        else $error("rxer without strobe");
    a_rxdv_crs: assert property (RXDV |-> CRS)
        else $error("rxdv without crs");
    a_bad_ssd: assert property (SPEED100 && RXER && !RXDV |-> RXD == 4'hE)
        else $error("bad start code");
    a_ssd_nibs: assert property ($rose(RXDV) && SPEED100 |-> preamble)
        else $error("no preamble");
    a_end_quiet: assert property ($fell(RXDV) && SPEED100 |-> !RX_NIB_STB [*5])
        else $error("data after end");
    a_nib_gate: assert property (nib_taken |-> TXEN && !SPEED100 && !JABBER)
        else $error("bad nibble take");
    a_first_half: assert property (nib_taken |=> TX10_DRIVE && TX10_LINE == !txd0_r)
        else $error("bad first half");
    a_jabber_stop: assert property (on_r >= 22'(JABBER_LIMIT + 12) |-> JABBER && !TX10_DRIVE)
        else $error("jabber late");
    a_jabber_clear: assert property ($fell(TXEN) |=> !JABBER)
        else $error("jabber held");
endmodule // phy_codec_chk
bind ethernet_phy_line_codec phy_codec_chk #(.JABBER_LIMIT(JABBER_LIMIT)) chk (
    .MCLK(MCLK), .NRST(NRST), .SPEED100(SPEED100), .TXEN(TXEN), .TXD(TXD), .RXD(RXD),
    .RXDV(RXDV), .RXER(RXER), .CRS(CRS), .RX_NIB_STB(RX_NIB_STB), .TX_NIB_STB(TX_NIB_STB),
    .TX10_LINE(TX10_LINE), .TX10_DRIVE(TX10_DRIVE), .JABBER(JABBER));

// ==== verification/mac_tx_model.sv ====
`timescale 1ns/1ps
module mac_tx_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       nib_stb,
    output logic            txen,
    output logic      [3:0] txd,
    output int              sent
);
    initial begin
        txen = 1'h0;
        txd  = 4'h0;
        sent = 0;
    end
    always @(posedge clk) begin
        txen <= go;
        if (nib_stb) begin
            txd  <= txd + 4'h1;
            sent <= sent + 1;
        end
    end
endmodule // mac_tx_model

// ==== verification/ethernet_phy_line_codec_tb.sv ====
`timescale 1ns/1ps
module ethernet_phy_line_codec_tb;
    import phy_codec_pkg::*;
    logic        mclk, nrst, spd, vld, sq, go, txen, rxdv, rxer, crs, stb, tstb, drv, jab, lk, up;
    logic [1:0]  lvl;
    logic [3:0]  txd, rxd;
    logic [10:0] key;
    logic [4:0]  q [$];
    logic [5:0]  got [$];
    int          fail_count, n_compared, sent, cyc = 0;
    ethernet_phy_line_codec #(.NLP_PERIOD(50), .JABBER_LIMIT(200), .LINK_LOSS(300)) uut (
        .MCLK(mclk), .NRST(nrst), .SPEED100(spd), .MLT3_LEVEL(lvl), .MLT3_VALID(vld),
        .RX10_LINE(1'h0), .RX10_SQ(sq), .TXEN(txen), .TXD(txd), .RXD(rxd), .RXDV(rxdv),
        .RXER(rxer), .CRS(crs), .RX_NIB_STB(stb), .DESCR_LOCKED(lk),
        .POLARITY_REVERSED_FLAG(), .LINK10_UP(up), .TX_NIB_STB(tstb), .TX10_LINE(),
        .TX10_DRIVE(drv), .JABBER(jab));
    mac_tx_model mac (.clk(mclk), .go(go), .nib_stb(tstb), .txen(txen), .txd(txd), .sent(sent));
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (stb) got.push_back({rxer, rxdv, rxd});
        if (cyc == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic check(string what, logic [5:0] seen, logic [5:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic grp(logic [4:0] g);
        logic k;
        for (int i = 4; i >= 0; i--) begin
            k = key[10] ^ key[8];
            @(posedge mclk);
            vld <= 1'h1;
            lvl <= lvl ^ {1'h0, g[i] ^ k};
            key = {key[9:0], k};
        end
    endtask
    task automatic send;
        got.delete();
        repeat (12) grp(CG_I);
        foreach (q[i]) grp(q[i]);
        repeat (4) grp(CG_I);
        @(posedge mclk);
        vld <= 1'h0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_frame;
        q = {CG_J, CG_K};
        for (int i = 0; i < 16; i++) q.push_back(DATA_CODE[i]);
        q.push_back(CG_T);
        q.push_back(CG_R);
        send();
        check("locked", lk, 6'h1);
        check("count", 6'(got.size()), 6'h12);
        for (int i = 0; i < 18; i++) check("nib", got[i], {2'h1, i < 2 ? 4'h5 : 4'(i - 2)});
        q = {CG_J, CG_K, DATA_CODE[9]};
        send();
        check("idle_end", {rxdv, crs, 4'(got.size())}, 6'h3);
        $display("frame test done");
    endtask
    task automatic t_errors;
        q = {CG_J, DATA_CODE[3]};
        send();
        check("bad_ssd", got[0], 6'h2E);
        q = {CG_J, CG_K, 5'h00, 5'h19, CG_T, DATA_CODE[1], CG_T, CG_R};
        send();
        check("inval", {got[2][5], got[3][5], got[4][5]}, 6'h7);
        $display("error test done");
    endtask
    task automatic t_ten;
        int n;
        spd <= 1'h0;
        sq  <= 1'h1;
        repeat (3) @(posedge mclk);
        sq <= 1'h0;
        repeat (5) @(posedge mclk);
        check("link", up, 6'h1);
        go <= 1'h1;
        repeat (8) @(posedge mclk);
        n = sent;
        repeat (100) @(posedge mclk);
        check("rate", 6'(sent - n), 6'hA);
        repeat (150) @(posedge mclk);
        check("jabber", {jab, drv}, 6'h2);
        go <= 1'h0;
        repeat (3) @(posedge mclk);
        check("jab_clr", jab, 6'h0);
        repeat (60) @(posedge mclk);
        n = 0;
        repeat (50) @(posedge mclk) n += drv;
        check("nlp", 6'(n), 6'h3);
        $display("10M test done");
    endtask
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {nrst, vld, sq, go, lvl} = 6'h0;
        spd = 1'h1;
        key = 11'h7FF;
        fail_count = 0;
        n_compared = 0;
        repeat (8) @(posedge mclk);
        nrst <= 1'h1;
        t_frame();
        t_errors();
        t_ten();
        stop_test();
    end
endmodule // ethernet_phy_line_codec_tb
